// ===== dv/pdm_pd_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdm_pd_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_port_power,
	input  wire logic [3:0] i_dc_ok,
	input  wire logic [3:0] i_ac_ok,
	output logic      [3:0] o_undercurrent,
	output logic      [3:0] o_ac_above_floor,
	output logic            o_osc
);
	import pdm_pkg::*;
	logic [4:0] div_ff;
	logic [4:0] nxt_div;
	// free running reference, period 32 cycles
	always_comb nxt_div = div_ff + 5'h01;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) div_ff <= 5'h00;
		else div_ff <= nxt_div;
	end
	assign o_osc = div_ff[4];
	// no current at all while unpowered
	assign o_undercurrent   = ~(i_dc_ok & i_port_power);
	assign o_ac_above_floor = i_ac_ok & i_port_power;
endmodule
`default_nettype wire

// ===== dv/port_disconnect_monitor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module port_disconnect_monitor_asserts #(
	parameter logic [pdm_pkg::TMR_W-1:0] P_DIS_CYC0  = pdm_pkg::DIS_CYC0,
	parameter logic [pdm_pkg::TMR_W-1:0] P_START_CYC = pdm_pkg::START_CYC
) (
	input wire logic                      i_ref_clk,
	input wire logic                      i_rst,
	input wire pdm_pkg::reg_req_s         i_reg_req,
	input wire logic [7:0]                o_reg_rdata,
	input wire logic                      o_reg_rvalid,
	input wire logic [pdm_pkg::NPORT-1:0] i_power_on,
	input wire logic [pdm_pkg::NPORT-1:0] i_power_off,
	input wire logic [pdm_pkg::NPORT-1:0] i_undercurrent,
	input wire logic [pdm_pkg::NPORT-1:0] i_ac_above_floor,
	input wire logic                      i_reference_osc_input,
	input wire logic [pdm_pkg::NPORT-1:0] o_port_power,
	input wire logic [pdm_pkg::NPORT-1:0] o_port_sense_drive,
	input wire logic [pdm_pkg::NPORT-1:0] o_disc_event,
	input wire logic                      o_irq
);
	import pdm_pkg::*;
	localparam logic [TMR_W-1:0] MIN_TRIP = P_START_CYC + P_DIS_CYC0 - TMR_W'(5);
	logic [TMR_W-1:0] on_cnt_ff;
	logic [TMR_W-1:0] nxt_on_cnt;
	// cycles port 0 has been powered
	always_comb nxt_on_cnt = o_port_power[0] ? on_cnt_ff + 1'b1 : '0;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) on_cnt_ff <= '0;
		else on_cnt_ff <= nxt_on_cnt;
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	disc_drop_a: assert property (
		(o_disc_event & (o_port_power | ~$past(o_port_power))) == '0) else $error("trip kept power");
	disc_pulse_a: assert property (
		(o_disc_event & $past(o_disc_event)) == '0) else $error("trip pulse too long");
	irq_reset_a: assert property ($past(i_rst) |-> o_irq) else $error("no irq after reset");
	irq_hold_a: assert property (
		o_irq && !(i_reg_req.wr && i_reg_req.addr == ADDR_MODE) |=> o_irq) else $error("irq lost");
	rd_answer_a: assert property (
		o_reg_rvalid == $past(i_reg_req.rd)) else $error("read answer timing");
	power_req_a: assert property (
		(o_port_power & ~$past(o_port_power) & ~$past(i_power_on)) == '0) else $error("unasked power");
	power_off_a: assert property (
		(o_port_power & $past(i_power_off)) == '0) else $error("power off ignored");
	start_hold_a: assert property (
		o_disc_event[0] |-> on_cnt_ff >= MIN_TRIP) else $error("trip too early");
	sense_gate_a: assert property (
		(o_port_sense_drive & ~o_port_power & ~$past(o_port_power)) == '0) else $error("drive unpowered");
	trip_c: cover property (o_disc_event[0]);
	irq_clear_c: cover property ($fell(o_irq));
	read_c: cover property (o_reg_rvalid);
endmodule
bind port_disconnect_monitor port_disconnect_monitor_asserts #(
	.P_DIS_CYC0 (P_DIS_CYC0),
	.P_START_CYC(P_START_CYC)
) u_asserts (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
	.o_reg_rvalid(o_reg_rvalid), .i_power_on(i_power_on), .i_power_off(i_power_off),
	.i_undercurrent(i_undercurrent), .i_ac_above_floor(i_ac_above_floor),
	.i_reference_osc_input(i_reference_osc_input), .o_port_power(o_port_power),
	.o_port_sense_drive(o_port_sense_drive), .o_disc_event(o_disc_event), .o_irq(o_irq)
);
`default_nettype wire

// ===== dv/port_disconnect_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_disconnect_monitor_tb;
	import pdm_pkg::*;
	localparam int LIM [4] = '{200, 240, 280, 320};
	logic       clk;
	logic       rst;
	reg_req_s   req;
	logic [7:0] rdata;
	logic       rvalid;
	logic       osc;
	logic       irq;
	logic [3:0] pon, poff, uc, acf, pwr, drv, disc, dcok, acok;
	int         n_mismatch;
	int         total_checks;

	port_disconnect_monitor #(
		.P_DIS_CYC0(TMR_W'(LIM[0])), .P_DIS_CYC1(TMR_W'(LIM[1])), .P_DIS_CYC2(TMR_W'(LIM[2])),
		.P_DIS_CYC3(TMR_W'(LIM[3])), .P_START_CYC(TMR_W'(20))
	) u_dut (
		.i_ref_clk(clk), .i_rst(rst), .i_reg_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_power_on(pon), .i_power_off(poff), .i_undercurrent(uc), .i_ac_above_floor(acf),
		.i_reference_osc_input(osc), .o_port_power(pwr), .o_port_sense_drive(drv),
		.o_disc_event(disc), .o_irq(irq)
	);
	pdm_pd_model u_pd (
		.i_ref_clk(clk), .i_rst(rst), .i_port_power(pwr), .i_dc_ok(dcok), .i_ac_ok(acok),
		.o_undercurrent(uc), .o_ac_above_floor(acf), .o_osc(osc)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic print_verdict();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) req <= '0;
		#1 chk({7'h00, rvalid}, 8'h01);
		chk(rdata, exp);
	endtask

	task automatic power_up();
		@(posedge clk) pon <= 4'h1;
		@(posedge clk) pon <= 4'h0;
		@(posedge clk);
	endtask

	// power port 0, two dropouts, then set port 0 dc/ac ok from dc and ac and time the trip, or check that none comes
	task automatic run(input logic [7:0] en, input logic dc, input logic ac, input int lim,
		input logic trip);
		int n;
		int hi;
		wr(ADDR_DISC_EN, en);
		power_up();
		repeat (60) @(posedge clk);
		hi = 0;
		repeat (64) begin
			@(posedge clk);
			#1 hi += drv[0];
		end
		chk({7'h00, hi > 0 && hi < 64}, {7'h00, en[AC_EN_LSB]});
		for (int g = 10; g < 200; g += 120) begin
			dcok <= 4'hE;
			acok <= 4'hE;
			repeat (g) @(posedge clk);
			dcok <= 4'hF;
			acok <= 4'hF;
			repeat (400) @(posedge clk);
		end
		dcok <= {3'b111, dc};
		acok <= {3'b111, ac};
		n = 0;
		while (n < 700 && disc[0] !== 1'b1) begin
			@(posedge clk);
			#1 n++;
		end
		if (trip) begin
			if (en[DC_EN_LSB]) begin
				chk({7'h00, n >= lim + GLITCH_CYC && n <= lim + GLITCH_CYC + 8}, 8'h01);
			end else begin
				chk({7'h00, n >= lim && n <= lim + 40}, 8'h01);
			end
		end else begin
			chk({7'h00, n == 700}, 8'h01);
			chk({4'h0, pwr}, 8'h01);
			@(posedge clk) poff <= 4'h1;
			@(posedge clk) poff <= 4'h0;
		end
		repeat (5) @(posedge clk);
		chk({4'h0, pwr}, 8'h00);
		rd(ADDR_FAULT, {3'b000, trip, 4'h0});
		wr(ADDR_FAULT, 8'h10);
		rd(ADDR_FAULT, 8'h00);
		dcok <= 4'hF;
		acok <= 4'hF;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		n_mismatch = 0;
		total_checks = 0;
		rst = 1'b1;
		req = '0;
		pon = 4'h0;
		poff = 4'h0;
		dcok = 4'hF;
		acok = 4'hF;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1 chk({7'h00, irq}, 8'h01);
		rd(ADDR_DISC_EN, DISC_EN_RST);
		rd(ADDR_TIMING, TIMING_RST);
		rd(8'h7F, 8'h00);
		power_up();
		#1 chk({4'h0, pwr}, 8'h00);
		wr(ADDR_MODE, {6'h00, MODE_NORMAL});
		#1 chk({7'h00, irq}, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_TIMING, 8'(s));
			run(8'h01, 1'b0, 1'b1, LIM[s], 1'b1);
		end
		run(8'h10, 1'b1, 1'b0, LIM[3], 1'b1);
		run(8'h11, 1'b0, 1'b1, LIM[3], 1'b0);
		run(8'h11, 1'b1, 1'b0, LIM[3], 1'b0);
		run(8'h00, 1'b0, 1'b0, LIM[3], 1'b0);
		rd(ADDR_TIMING, 8'h03);
		print_verdict();
	end
endmodule
`default_nettype wire

// ===== logic/pdm_ac_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pdm_ac_detect (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_rst,
	input  wire logic                    i_osc,
	input  wire logic [pdm_pkg::NPORT-1:0] i_above_floor,
	input  wire logic [pdm_pkg::NPORT-1:0] i_enable,
	output logic      [pdm_pkg::NPORT-1:0] o_keepalive
);
	import pdm_pkg::*;

	logic             osc_prev_ff;
	logic [NPORT-1:0] seen_ff;
	logic [NPORT-1:0] keep_ff;
	logic [NPORT-1:0] nxt_seen;
	logic [NPORT-1:0] nxt_keep;
	logic             period_edge;

	assign period_edge = i_osc & ~osc_prev_ff;

	// one keepalive per oscillator period, only if current exceeded the floor
	always_comb begin
		nxt_seen = seen_ff | i_above_floor;
		nxt_keep = '0;
		if (period_edge) begin
			nxt_keep = (seen_ff | i_above_floor) & i_enable;
			nxt_seen = '0;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			osc_prev_ff <= 1'b0;
			seen_ff     <= '0;
			keep_ff     <= '0;
		end else begin
			osc_prev_ff <= i_osc;
			seen_ff     <= nxt_seen;
			keep_ff     <= nxt_keep;
		end
	end

	assign o_keepalive = keep_ff;
endmodule
`default_nettype wire

// ===== logic/pdm_in_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pdm_in_filter #(
	parameter int         W    = 4,
	parameter logic [7:0] FILT = 8'h01
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level
);
	for (genvar b = 0; b < W; b++) begin : g_bit
		logic       s1_ff;
		logic       s2_ff;
		logic       s3_ff;
		logic       out_ff;
		logic [7:0] cnt_ff;
		logic       nxt_out;
		logic [7:0] nxt_cnt;

		// change counts once stage two and three agree and hold for FILT cycles
		always_comb begin
			nxt_out = out_ff;
			nxt_cnt = 8'h00;
			if (s2_ff == s3_ff && s3_ff != out_ff) begin
				nxt_cnt = cnt_ff + 8'h01;
				if (nxt_cnt >= FILT) begin
					nxt_out = s3_ff;
					nxt_cnt = 8'h00;
				end
			end
		end

		always_ff @(posedge i_ref_clk or posedge i_rst) begin
			if (i_rst) begin
				s1_ff  <= 1'b0;
				s2_ff  <= 1'b0;
				s3_ff  <= 1'b0;
				out_ff <= 1'b0;
				cnt_ff <= 8'h00;
			end else begin
				s1_ff  <= i_async[b];
				s2_ff  <= s1_ff;
				s3_ff  <= s2_ff;
				out_ff <= nxt_out;
				cnt_ff <= nxt_cnt;
			end
		end

		assign o_level[b] = out_ff;
	end
endmodule
`default_nettype wire

// ===== logic/pdm_pkg.sv
`default_nettype none
package pdm_pkg;
	localparam int          NPORT        = 4;
	localparam int          TMR_W        = 26;
	localparam longint      CLK_HZ       = 40_000_000;
	localparam logic [7:0]  ADDR_POWER   = 8'h10;
	localparam logic [7:0]  ADDR_MODE    = 8'h12;
	localparam logic [7:0]  ADDR_DISC_EN = 8'h13;
	localparam logic [7:0]  ADDR_TIMING  = 8'h16;
	localparam logic [7:0]  ADDR_FAULT   = 8'h06;
	localparam int          DC_EN_LSB    = 0;
	localparam int          AC_EN_LSB    = 4;
	localparam int          DISCONNECT_TIMEOUT_LSB     = 0;
	localparam int          FAULT_LSB    = 4;
	localparam int          MODE_LSB     = 0;
	localparam logic [1:0]  MODE_NORMAL  = 2'h3;
	localparam logic [1:0]  MODE_RST     = 2'h0;
	localparam logic [7:0]  DISC_EN_RST  = 8'h0F;
	localparam logic [7:0]  TIMING_RST   = 8'h00;
	localparam longint      DIS_MS0      = 75;
	localparam longint      DIS_MS1      = 150;
	localparam longint      DIS_MS2      = 300;
	localparam longint      DIS_MS3      = 600;
	localparam longint      START_MS     = 60;
	localparam longint      GLITCH_NS    = 1000;
	localparam logic [TMR_W-1:0] DIS_CYC0  = TMR_W'(DIS_MS0 * CLK_HZ / 1000);
	localparam logic [TMR_W-1:0] DIS_CYC1  = TMR_W'(DIS_MS1 * CLK_HZ / 1000);
	localparam logic [TMR_W-1:0] DIS_CYC2  = TMR_W'(DIS_MS2 * CLK_HZ / 1000);
	localparam logic [TMR_W-1:0] DIS_CYC3  = TMR_W'(DIS_MS3 * CLK_HZ / 1000);
	localparam logic [TMR_W-1:0] START_CYC = TMR_W'(START_MS * CLK_HZ / 1000);
	localparam logic [7:0]  GLITCH_CYC   = 8'((GLITCH_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
	localparam logic [7:0]  NO_FILT_CYC  = 8'h01;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef enum logic [2:0] {
		ST_OFF   = 3'b001,
		ST_START = 3'b010,
		ST_ON    = 3'b100
	} port_state_e;
endpackage
`default_nettype wire

// ===== logic/port_disconnect_monitor.sv
// Function
// - while a powered port has DC sensing on, its disconnect timer advances during undercurrent.
// - when a port's disconnect timer expires, the port is switched off and its fault flag set.
// - when undercurrent ends before timeout, the timer clears so a new episode starts at zero.
// - the undercurrent indication is glitch filtered before it may affect the timer.
// - a cleared DC enable bit in register 13h keeps undercurrent sensing away from that port.
// - bits 1:0 of register 16h pick the disconnect timeout for both sensing methods.
// - with AC sensing on, the timer advances while AC current stays under its floor, then trips.
// - AC current rising over the floor before full count resets the timer and keeps power.
// - a cleared AC enable bit in register 13h keeps impedance sensing away from that port.
// - the AC path resets the timer at most once per oscillator period, only if the floor was met.
// - AC and DC timer resets are ORed, so either enabled method alone keeps the port up.
// - after an internal reset the interrupt output rises and the host restores normal mode.
// - the disconnect timer is held off during the startup window and counts only after it.
`timescale 1ns/1ps
`default_nettype none
module port_disconnect_monitor #(
	parameter logic [pdm_pkg::TMR_W-1:0] P_DIS_CYC0 = pdm_pkg::DIS_CYC0,
	parameter logic [pdm_pkg::TMR_W-1:0] P_DIS_CYC1 = pdm_pkg::DIS_CYC1,
	parameter logic [pdm_pkg::TMR_W-1:0] P_DIS_CYC2 = pdm_pkg::DIS_CYC2,
	parameter logic [pdm_pkg::TMR_W-1:0] P_DIS_CYC3 = pdm_pkg::DIS_CYC3,
	parameter logic [pdm_pkg::TMR_W-1:0] P_START_CYC = pdm_pkg::START_CYC
) (
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_rst,
	input  wire pdm_pkg::reg_req_s         i_reg_req,
	output logic      [7:0]                o_reg_rdata,
	output logic                           o_reg_rvalid,
	input  wire logic [pdm_pkg::NPORT-1:0] i_power_on,
	input  wire logic [pdm_pkg::NPORT-1:0] i_power_off,
	input  wire logic [pdm_pkg::NPORT-1:0] i_undercurrent,
	input  wire logic [pdm_pkg::NPORT-1:0] i_ac_above_floor,
	input  wire logic                      i_reference_osc_input,
	output logic      [pdm_pkg::NPORT-1:0] o_port_power,
	output logic      [pdm_pkg::NPORT-1:0] o_port_sense_drive,
	output logic      [pdm_pkg::NPORT-1:0] o_disc_event,
	output logic                           o_irq
);
	import pdm_pkg::*;

	// register file state
	logic [7:0]       disc_en_ff;
	logic [7:0]       timing_ff;
	logic [1:0]       mode_ff;
	logic [NPORT-1:0] fault_ff;
	logic             irq_ff;
	logic [7:0]       rdata_ff;
	logic             rvalid_ff;
	logic [7:0]       nxt_disc_en;
	logic [7:0]       nxt_timing;
	logic [1:0]       nxt_mode;
	logic [NPORT-1:0] nxt_fault;
	logic             nxt_irq;
	logic [7:0]       nxt_rdata;
	logic             nxt_rvalid;

	// detector and timer wiring
	logic [NPORT-1:0] uc_filt;
	logic [NPORT-1:0] ac_level;
	logic             osc_level;
	logic [NPORT-1:0] ac_keep;
	logic [NPORT-1:0] dc_en;
	logic [NPORT-1:0] ac_en;
	logic [NPORT-1:0] expire;
	logic [NPORT-1:0] powered;
	logic [TMR_W-1:0] dis_lim;

	// port output stage
	logic [NPORT-1:0] power_ff;
	logic [NPORT-1:0] drive_ff;
	logic [NPORT-1:0] event_ff;
	logic [NPORT-1:0] nxt_power;
	logic [NPORT-1:0] nxt_drive;
	logic [NPORT-1:0] nxt_event;

	// per-port method enables
	assign dc_en = disc_en_ff[DC_EN_LSB +: NPORT];
	assign ac_en = disc_en_ff[AC_EN_LSB +: NPORT];

	// undercurrent comparator outputs, synchronised and glitch filtered
	pdm_in_filter #(
		.W    (NPORT),
		.FILT (GLITCH_CYC)
	) u_uc_filt (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_async   (i_undercurrent),
		.o_level   (uc_filt)
	);

	// ac floor comparators and reference oscillator, synchronised only
	pdm_in_filter #(
		.W    (NPORT + 1),
		.FILT (NO_FILT_CYC)
	) u_ac_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_async   ({i_reference_osc_input, i_ac_above_floor}),
		.o_level   ({osc_level, ac_level})
	);

	// one keepalive pulse per oscillator period
	pdm_ac_detect u_ac_detect (
		.i_ref_clk     (i_ref_clk),
		.i_rst         (i_rst),
		.i_osc         (osc_level),
		.i_above_floor (ac_level),
		.i_enable      (ac_en),
		.o_keepalive   (ac_keep)
	);

	// timeout selection shared by both sensing methods
	always_comb begin
		unique case (timing_ff[DISCONNECT_TIMEOUT_LSB +: 2])
			2'h0: dis_lim = P_DIS_CYC0;
			2'h1: dis_lim = P_DIS_CYC1;
			2'h2: dis_lim = P_DIS_CYC2;
			2'h3: dis_lim = P_DIS_CYC3;
		endcase
	end

	// per-port start window, disconnect timer and trip
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		port_state_e      state_ff;
		port_state_e      nxt_state;
		logic [TMR_W-1:0] start_ff;
		logic [TMR_W-1:0] nxt_start;
		logic [TMR_W-1:0] dis_ff;
		logic [TMR_W-1:0] nxt_dis;
		// keepalive and trip terms
		logic             dc_keep;
		logic             keep;
		logic             armed;
		logic             trip;

		// either method's keepalive clears the timer; a full count with none trips
		assign dc_keep = dc_en[p] & ~uc_filt[p];
		assign keep    = dc_keep | ac_keep[p];
		assign armed   = (state_ff == ST_ON) & (dc_en[p] | ac_en[p]);
		assign trip    = armed & ~keep & (dis_ff >= dis_lim - TMR_W'(1));

		// off, then start window, then on; power off or a trip returns to off
		always_comb begin
			nxt_state = state_ff;
			nxt_start = '0;
			nxt_dis   = '0;
			unique case (state_ff)
				ST_OFF: begin
					// power requests only in normal mode
					if (i_power_on[p] && mode_ff == MODE_NORMAL) begin
						nxt_state = ST_START;
					end
				end
				ST_START: begin
					// disconnect timer held clear for the whole window
					nxt_start = start_ff + TMR_W'(1);
					if (i_power_off[p]) begin
						nxt_state = ST_OFF;
					end else if (start_ff >= P_START_CYC - TMR_W'(1)) begin
						nxt_state = ST_ON;
						nxt_start = '0;
					end
				end
				ST_ON: begin
					// power off wins over the timer
					if (i_power_off[p] || trip) begin
						nxt_state = ST_OFF;
					end else if (armed && !keep) begin
						nxt_dis = dis_ff + TMR_W'(1);
					end else begin
						nxt_dis = '0;
					end
				end
				// a corrupted one-hot code recovers to off
				default: begin
					nxt_state = ST_OFF;
				end
			endcase
		end

		always_ff @(posedge i_ref_clk or posedge i_rst) begin
			if (i_rst) begin
				state_ff <= ST_OFF;
				start_ff <= '0;
				dis_ff   <= '0;
			end else begin
				state_ff <= nxt_state;
				start_ff <= nxt_start;
				dis_ff   <= nxt_dis;
			end
		end

		// a same-cycle power off request wins, so no fault is flagged
		assign expire[p]  = trip & (state_ff == ST_ON) & ~i_power_off[p];
		assign powered[p] = (nxt_state != ST_OFF);
	end

	// port outputs
	always_comb begin
		nxt_power = powered;
		// sense drive follows the oscillator while powered with AC sensing on
		nxt_drive = powered & ac_en & {NPORT{osc_level}};
		// one-cycle trip pulse
		nxt_event = expire;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			power_ff <= '0;
			drive_ff <= '0;
			event_ff <= '0;
		end else begin
			power_ff <= nxt_power;
			drive_ff <= nxt_drive;
			event_ff <= nxt_event;
		end
	end

	// register file: writes, fault flags, interrupt and read data
	always_comb begin
		nxt_disc_en = disc_en_ff;
		nxt_timing  = timing_ff;
		nxt_mode    = mode_ff;
		nxt_fault   = fault_ff;
		nxt_irq     = irq_ff;
		nxt_rdata   = rdata_ff;
		nxt_rvalid  = 1'b0;
		// writes to unmapped or read-only addresses are ignored
		if (i_reg_req.wr) begin
			unique case (i_reg_req.addr)
				ADDR_DISC_EN: nxt_disc_en = i_reg_req.wdata;
				ADDR_TIMING:  nxt_timing  = i_reg_req.wdata;
				ADDR_MODE: begin
					nxt_mode = i_reg_req.wdata[MODE_LSB +: 2];
					// entering normal mode acknowledges the reset interrupt
					if (i_reg_req.wdata[MODE_LSB +: 2] == MODE_NORMAL) begin
						nxt_irq = 1'b0;
					end
				end
				ADDR_FAULT: begin
					// write 1 clears
					nxt_fault = fault_ff & ~i_reg_req.wdata[FAULT_LSB +: NPORT];
				end
				default: begin
				end
			endcase
		end
		// a trip in the same cycle as a clear still sets the flag
		nxt_fault = nxt_fault | expire;
		// read answer registered one cycle after the request
		if (i_reg_req.rd) begin
			nxt_rvalid = 1'b1;
			unique case (i_reg_req.addr)
				ADDR_DISC_EN: nxt_rdata = disc_en_ff;
				ADDR_TIMING:  nxt_rdata = timing_ff;
				ADDR_MODE: begin
					nxt_rdata = 8'h00;
					nxt_rdata[MODE_LSB +: 2] = mode_ff;
				end
				ADDR_FAULT: begin
					nxt_rdata = 8'h00;
					nxt_rdata[FAULT_LSB +: NPORT] = fault_ff;
				end
				ADDR_POWER: begin
					nxt_rdata = 8'h00;
					nxt_rdata[NPORT-1:0] = power_ff;
				end
				default:      nxt_rdata = 8'h00;
			endcase
		end
	end

	// reset leaves DC sensing on, the shortest timeout and the interrupt raised
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			disc_en_ff <= DISC_EN_RST;
			timing_ff  <= TIMING_RST;
			mode_ff    <= MODE_RST;
			fault_ff   <= '0;
			irq_ff     <= 1'b1;
			rdata_ff   <= 8'h00;
			rvalid_ff  <= 1'b0;
		end else begin
			disc_en_ff <= nxt_disc_en;
			timing_ff  <= nxt_timing;
			mode_ff    <= nxt_mode;
			fault_ff   <= nxt_fault;
			irq_ff     <= nxt_irq;
			rdata_ff   <= nxt_rdata;
			rvalid_ff  <= nxt_rvalid;
		end
	end

	// every output straight from a register
	assign o_reg_rdata        = rdata_ff;
	assign o_reg_rvalid       = rvalid_ff;
	assign o_port_power       = power_ff;
	assign o_port_sense_drive = drive_ff;
	assign o_disc_event       = event_ff;
	assign o_irq              = irq_ff;
endmodule
`default_nettype wire

// ===== logic/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
